// ---- core/tstrt_regs.svh ----
// constants for the test routing and self test block
`ifndef TSTRT_REGS_SVH
`define TSTRT_REGS_SVH
`define TSTRT_SELFTEST_ARM    8'h09
`define TSTRT_SIG_BYTES       7'd64
`define TSTRT_BUS_RX          5'h07
`define TSTRT_BUS_OSC         5'h0D
`define TSTRT_AUX_RXACT       4'hD
`define TSTRT_AUX_SUBC        4'hE
`define TSTRT_AUX_PROBE       4'hF
`define TSTRT_AUX_DAC1        4'h1
`define TSTRT_AUX_DAC2        4'h1
`define TSTRT_AUX_CORR        4'h2
`define TSTRT_AUX_MINLVL      4'h4
`define TSTRT_AUX_ADCI        4'h5
`define TSTRT_AUX_ADCQ        4'h6
`define TSTRT_AUX_TXACT       4'hC
`define TSTRT_PRBS_OFF        2'h0
`define TSTRT_PRBS9           2'h1
`define TSTRT_PRBS15          2'h2
`define TSTRT_OSC_DIV         3'h3
`define TSTRT_PRBS9_SEED      15'h01FF
`define TSTRT_PRBS15_SEED     15'h7FFF
`endif

// ---- core/tstrt_pkg.sv ----
// types for the test routing and self test block
package tstrt_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_DUMP = 4'b0100,
    ST_DONE = 4'b1000
  } tstrt_st_t;
  typedef struct packed {
    logic       rx_data;
    logic       rx_coll;
    logic       rx_valid;
    logic       rx_over;
    logic       rx_reset;
  } tstrt_rx_t;
  typedef struct packed {
    logic       start_bit;
    logic       data_bit;
    logic       parity_bit;
    logic       crc_bit;
    logic       speed_106;
  } tstrt_phase_t;
endpackage

// ---- core/tstrt_sigrom.sv ----
// signature memory: 64 bytes, registered read
`timescale 1ns/1ps
module tstrt_sigrom (
  input  wire logic       clk,
  input  wire logic [5:0] addr,
  output logic      [7:0] data
);
  // =========================================================
  // lookup
  logic [7:0] rom_v;
  always_comb begin
    case (addr)
      6'h00: rom_v = 8'h00; 6'h01: rom_v = 8'hEB; 6'h02: rom_v = 8'h66; 6'h03: rom_v = 8'hBA;
      6'h04: rom_v = 8'h57; 6'h05: rom_v = 8'hBF; 6'h06: rom_v = 8'h23; 6'h07: rom_v = 8'h95;
      6'h08: rom_v = 8'hD0; 6'h09: rom_v = 8'hE3; 6'h0A: rom_v = 8'h0D; 6'h0B: rom_v = 8'h3D;
      6'h0C: rom_v = 8'h27; 6'h0D: rom_v = 8'h89; 6'h0E: rom_v = 8'h5C; 6'h0F: rom_v = 8'hDE;
      6'h10: rom_v = 8'h9D; 6'h11: rom_v = 8'h3B; 6'h12: rom_v = 8'hA7; 6'h13: rom_v = 8'h00;
      6'h14: rom_v = 8'h21; 6'h15: rom_v = 8'h5B; 6'h16: rom_v = 8'h89; 6'h17: rom_v = 8'h82;
      6'h18: rom_v = 8'h51; 6'h19: rom_v = 8'h3A; 6'h1A: rom_v = 8'hEB; 6'h1B: rom_v = 8'h02;
      6'h1C: rom_v = 8'h0C; 6'h1D: rom_v = 8'hA5; 6'h1E: rom_v = 8'h00; 6'h1F: rom_v = 8'h49;
      6'h20: rom_v = 8'h7C; 6'h21: rom_v = 8'h84; 6'h22: rom_v = 8'h4D; 6'h23: rom_v = 8'hB3;
      6'h24: rom_v = 8'hCC; 6'h25: rom_v = 8'hD2; 6'h26: rom_v = 8'h1B; 6'h27: rom_v = 8'h81;
      6'h28: rom_v = 8'h5D; 6'h29: rom_v = 8'h48; 6'h2A: rom_v = 8'h76; 6'h2B: rom_v = 8'hD5;
      6'h2C: rom_v = 8'h71; 6'h2D: rom_v = 8'h61; 6'h2E: rom_v = 8'h21; 6'h2F: rom_v = 8'hA9;
      6'h30: rom_v = 8'h86; 6'h31: rom_v = 8'h96; 6'h32: rom_v = 8'h83; 6'h33: rom_v = 8'h38;
      6'h34: rom_v = 8'hCF; 6'h35: rom_v = 8'h9D; 6'h36: rom_v = 8'h5B; 6'h37: rom_v = 8'h6D;
      6'h38: rom_v = 8'hDC; 6'h39: rom_v = 8'h15; 6'h3A: rom_v = 8'hBA; 6'h3B: rom_v = 8'h3E;
      6'h3C: rom_v = 8'h7D; 6'h3D: rom_v = 8'h95; 6'h3E: rom_v = 8'h3B; default: rom_v = 8'h2F;
    endcase
  end
  // =========================================================
  // registered read port, no reset needed for a constant table
  always_ff @(posedge clk) begin
    data <= rom_v;
  end
endmodule // tstrt_sigrom

// ---- core/tstrt_top.sv ----
// test routing, probe bus, aux pin selection, prbs and self test signature
`timescale 1ns/1ps
`include "tstrt_regs.svh"
module tstrt_top (
  input  wire logic                 MCLK,
  input  wire logic                 NRST,
  input  wire logic                 SOFT_RESET,
  input  wire logic [7:0]           SELF_TEST_CONTROL,
  input  wire logic                 CRC_CALCULATE_COMMAND,
  input  wire logic                 TRANSMIT_COMMAND,
  input  wire logic                 FRAME_END,
  input  wire logic [4:0]           PROBE_GROUP_SELECTOR,
  input  wire logic [2:0]           PROBE_LINE_SELECTOR,
  input  wire logic [1:0]           PRBS_SELECT,
  input  wire logic [3:0]           FIRST_AUX_SOURCE,
  input  wire logic [3:0]           SECOND_AUX_SOURCE,
  input  wire logic [5:0]           FIRST_DAC_VALUE,
  input  wire logic [5:0]           SECOND_DAC_VALUE,
  input  wire logic [5:0]           CORRELATOR_OUTPUT,
  input  wire logic [5:0]           MINIMUM_LEVEL_SIGNAL,
  input  wire logic [5:0]           ADC_I,
  input  wire logic [5:0]           ADC_Q,
  input  wire tstrt_pkg::tstrt_rx_t RX_SIG,
  input  wire tstrt_pkg::tstrt_phase_t RX_PHASE,
  input  wire tstrt_pkg::tstrt_phase_t TX_PHASE,
  input  wire logic                 SUBCARRIER_DETECTED,
  input  wire logic                 OSCILLATOR_STABLE,
  input  wire logic                 OSCILLATOR_RAW,
  output logic [6:1]                PROBE_LINES,
  output logic [5:0]                FIRST_AUX_PIN,
  output logic [5:0]                SECOND_AUX_PIN,
  output logic                      RECEIVE_IN_PROGRESS,
  output logic                      TRANSMIT_IN_PROGRESS,
  output logic                      PRBS_ACTIVE,
  output logic                      PRBS_BIT,
  output logic                      FIFO_WRITE,
  output logic [7:0]                FIFO_WDATA,
  output logic                      SELF_TEST_BUSY
);
  import tstrt_pkg::*;

  // =========================================================
  // state record
  typedef struct packed {
    tstrt_st_t  st;
    logic [6:0] cnt;
    logic       armed;
    logic [2:0] div;
    logic [14:0] lfsr;
    logic       prbs_on;
    logic       prbs15;
    logic [6:1] probe;
    logic [5:0] first_aux_pin;
    logic [5:0] second_aux_pin;
    logic       rxa;
    logic       txa;
    logic       fwr;
    logic [7:0] fdat;
    logic       busy;
  } tstrt_state_t;

  tstrt_state_t s_q;
  tstrt_state_t s_d;
  logic [7:0]   rom_data;
  logic [5:0]   rom_addr;
  logic [7:0]   probe_group;
  logic         probe_bit;
  logic         rxa_v;
  logic         txa_v;
  logic         fb;

  // address leads the registered rom output by one cycle
  assign rom_addr = s_q.cnt[5:0];

  tstrt_sigrom u_rom (
    .clk  (MCLK),
    .addr (rom_addr),
    .data (rom_data)
  );

  // =========================================================
  // activity indicators, depending on the bit rate
  always_comb begin
    // 106k keeps tx high over start bits, rx never shows them
    rxa_v = RX_PHASE.data_bit | RX_PHASE.crc_bit
          | (RX_PHASE.speed_106 & RX_PHASE.parity_bit);
    txa_v = TX_PHASE.data_bit | TX_PHASE.crc_bit
          | (TX_PHASE.speed_106 & (TX_PHASE.parity_bit | TX_PHASE.start_bit));
  end

  // =========================================================
  // probe bus groups
  always_comb begin
    probe_group = 8'h00;
    case (PROBE_GROUP_SELECTOR)
      `TSTRT_BUS_RX:
        probe_group = {1'b0, RX_SIG.rx_data, RX_SIG.rx_coll, RX_SIG.rx_valid,
                       RX_SIG.rx_over, RX_SIG.rx_reset, 1'b0, 1'b0};
      `TSTRT_BUS_OSC:
        probe_group = {1'b0, OSCILLATOR_STABLE, s_q.div[2], 1'b0, 1'b0,
                       OSCILLATOR_RAW, 1'b0, 1'b0};
      default: probe_group = 8'h00;
    endcase
    probe_bit = probe_group[PROBE_LINE_SELECTOR];
  end

  // one aux pin source; 6 bit level, digital sources drive full scale
  function automatic logic [5:0] aux_pick(input logic [3:0] sel, input logic first);
    logic [5:0] r;
    r = 6'h00;
    case (sel)
      `TSTRT_AUX_DAC1: r = first ? FIRST_DAC_VALUE : SECOND_DAC_VALUE;
      `TSTRT_AUX_CORR: r = CORRELATOR_OUTPUT;
      `TSTRT_AUX_MINLVL: r = MINIMUM_LEVEL_SIGNAL;
      `TSTRT_AUX_ADCI: r = ADC_I;
      `TSTRT_AUX_ADCQ: r = ADC_Q;
      // apart from code 1, which picks each pin's own dac, the same code means the same source on either pin
      `TSTRT_AUX_RXACT: r = {6{rxa_v}};
      `TSTRT_AUX_TXACT: r = {6{txa_v}};
      `TSTRT_AUX_SUBC: r = {6{SUBCARRIER_DETECTED}};
      `TSTRT_AUX_PROBE: r = {6{probe_bit}};
      default: r = 6'h00;
    endcase
    return r;
  endfunction

  // =========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.fwr = 1'b0;
    s_d.div = 3'(s_q.div + 3'h1);
    s_d.probe = probe_group[6:1];
    s_d.first_aux_pin = aux_pick(FIRST_AUX_SOURCE, 1'b1);
    s_d.second_aux_pin = aux_pick(SECOND_AUX_SOURCE, 1'b0);
    s_d.rxa = rxa_v;
    s_d.txa = txa_v;
    s_d.armed = (SELF_TEST_CONTROL == `TSTRT_SELFTEST_ARM);
    // prbs: start on transmit, stop at frame end or deselect
    fb = s_q.prbs15 ? (s_q.lfsr[14] ^ s_q.lfsr[13]) : (s_q.lfsr[8] ^ s_q.lfsr[4]);
    if (s_q.prbs_on) begin
      // shifting only on payload bits; framing bits come from the framer
      if (TX_PHASE.data_bit) begin
        s_d.lfsr = {s_q.lfsr[13:0], fb};
      end
      if (FRAME_END || PRBS_SELECT == `TSTRT_PRBS_OFF) begin
        s_d.prbs_on = 1'b0;
      end
    end else if (TRANSMIT_COMMAND && PRBS_SELECT != `TSTRT_PRBS_OFF) begin
      s_d.prbs_on = 1'b1;
      s_d.prbs15 = (PRBS_SELECT == `TSTRT_PRBS15);
      s_d.lfsr = (PRBS_SELECT == `TSTRT_PRBS15) ? `TSTRT_PRBS15_SEED : `TSTRT_PRBS9_SEED;
    end
    // self test sequencer
    case (s_q.st)
      ST_IDLE: begin
        if (CRC_CALCULATE_COMMAND && s_q.armed) begin
          s_d.st = ST_WAIT;
          s_d.cnt = 7'h00;
        end
      end
      ST_WAIT: begin
        s_d.st = ST_DUMP;
        s_d.cnt = 7'h01;
      end
      ST_DUMP: begin
        s_d.fwr = 1'b1;
        s_d.fdat = rom_data;
        s_d.cnt = 7'(s_q.cnt + 7'h01);
        if (s_q.cnt == `TSTRT_SIG_BYTES) begin
          s_d.st = ST_DONE;
        end
      end
      ST_DONE: s_d.st = ST_IDLE;
      default: s_d.st = ST_IDLE;
    endcase
    if (SOFT_RESET) begin
      s_d.st = ST_IDLE;
      s_d.prbs_on = 1'b0;
      s_d.fwr = 1'b0;
    end
    // busy is kept as its own flop so the output needs no decode
    s_d.busy = (s_d.st != ST_IDLE);
  end

  // =========================================================
  // state register
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      s_q <= '{st: ST_IDLE, lfsr: 15'h7FFF, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign PROBE_LINES          = s_q.probe;
  assign FIRST_AUX_PIN        = s_q.first_aux_pin;
  assign SECOND_AUX_PIN       = s_q.second_aux_pin;
  assign RECEIVE_IN_PROGRESS  = s_q.rxa;
  assign TRANSMIT_IN_PROGRESS = s_q.txa;
  assign PRBS_ACTIVE          = s_q.prbs_on;
  assign PRBS_BIT             = s_q.lfsr[0];
  assign FIFO_WRITE           = s_q.fwr;
  assign FIFO_WDATA           = s_q.fdat;
  assign SELF_TEST_BUSY       = s_q.busy;
endmodule // tstrt_top

// ---- bench/tstrt_host_model.sv ----
// host controller model that runs the self test sequence
`timescale 1ns/1ps
module tstrt_host_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       busy,
  output logic            soft_rst,
  output logic      [7:0] ctrl,
  output logic            crc_cmd,
  output logic            done
);
  // ====================================
  // self test sequence, run once after the first go
  initial begin
    soft_rst = 1'b0;
    ctrl = 8'h00;
    crc_cmd = 1'b0;
    done = 1'b0;
    wait (go);
    @(posedge clk);
    #1 soft_rst = 1'b1;
    @(posedge clk);
    #1 soft_rst = 1'b0;
    ctrl = 8'h09;
    @(posedge clk);
    #1 crc_cmd = 1'b1;
    @(posedge clk);
    #1 crc_cmd = 1'b0;
    // bounded wait for idle before the buffer may be read
    for (int i = 0; i < 100 && (busy || i < 2); i++) @(posedge clk);
    #1 ctrl = 8'h00;
    done = 1'b1;
  end
endmodule // tstrt_host_model

// ---- bench/tstrt_top_properties.sv ----
// port checker for the test routing block
`timescale 1ns/1ps
module tstrt_top_properties
  import tstrt_pkg::*;
(
  input wire logic         MCLK,
  input wire logic         NRST,
  input wire logic [7:0]   SELF_TEST_CONTROL,
  input wire logic         CRC_CALCULATE_COMMAND,
  input wire logic [4:0]   PROBE_GROUP_SELECTOR,
  input wire logic [3:0]   FIRST_AUX_SOURCE,
  input wire logic [3:0]   SECOND_AUX_SOURCE,
  input wire logic [5:0]   FIRST_DAC_VALUE,
  input wire logic [5:0]   SECOND_DAC_VALUE,
  input wire logic [5:0]   ADC_I,
  input wire logic         SUBCARRIER_DETECTED,
  input wire tstrt_rx_t    RX_SIG,
  input wire tstrt_phase_t RX_PHASE,
  input wire tstrt_phase_t TX_PHASE,
  input wire logic [6:1]   PROBE_LINES,
  input wire logic [5:0]   FIRST_AUX_PIN,
  input wire logic [5:0]   SECOND_AUX_PIN,
  input wire logic         RECEIVE_IN_PROGRESS,
  input wire logic         TRANSMIT_IN_PROGRESS,
  input wire logic         FIFO_WRITE,
  input wire logic [7:0]   FIFO_WDATA,
  input wire logic         SELF_TEST_BUSY
);
  // ====================================
  // routed outputs lag one cycle; guard the edge after reset
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);
  sequence s_launch;
    $past(NRST) && $past(SELF_TEST_CONTROL) == 8'h09 && CRC_CALCULATE_COMMAND && !SELF_TEST_BUSY;
  endsequence
  sequence s_first_bytes;
    FIFO_WRITE && FIFO_WDATA == 8'h00 ##1 FIFO_WRITE && FIFO_WDATA == 8'hEB;
  endsequence
  a_st_launch: assert property (s_launch |=> SELF_TEST_BUSY ##2 s_first_bytes)
    else $error("self test did not start");
  a_dac_first: assert property ($past(NRST) && $past(FIRST_AUX_SOURCE) == 4'h1
    |-> FIRST_AUX_PIN == $past(FIRST_DAC_VALUE)) else $error("dac one");
  a_dac_second: assert property ($past(NRST) && $past(SECOND_AUX_SOURCE) == 4'h1
    |-> SECOND_AUX_PIN == $past(SECOND_DAC_VALUE)) else $error("dac two");
  a_adc_route: assert property ($past(NRST) && $past(FIRST_AUX_SOURCE) == 4'h5
    |-> FIRST_AUX_PIN == $past(ADC_I)) else $error("adc route");
  a_subc_route: assert property ($past(NRST) && $past(FIRST_AUX_SOURCE) == 4'hE
    |-> FIRST_AUX_PIN == {6{$past(SUBCARRIER_DETECTED)}}) else $error("subcarrier");
  a_rx_group: assert property ($past(NRST) && $past(PROBE_GROUP_SELECTOR) == 5'h07
    |-> PROBE_LINES == {$past(RX_SIG), 1'b0}) else $error("rx group");
  a_start_rx: assert property ($past(NRST) && $past(RX_PHASE) inside {5'b10000, 5'b10001}
    |-> !RECEIVE_IN_PROGRESS) else $error("rx start bit");
  a_start_tx: assert property ($past(NRST && TX_PHASE.speed_106 && TX_PHASE.start_bit)
    |-> TRANSMIT_IN_PROGRESS) else $error("tx start bit");
  a_fast_tx: assert property ($past(NRST && !TX_PHASE.speed_106 && TX_PHASE.crc_bit)
    |-> TRANSMIT_IN_PROGRESS) else $error("fast tx crc");
  a_code_rxact: assert property ($past(NRST) && $past(SECOND_AUX_SOURCE) == 4'hD
    |-> SECOND_AUX_PIN == {6{RECEIVE_IN_PROGRESS}}) else $error("rx activity code");
  a_code_txact: assert property ($past(NRST) && $past(FIRST_AUX_SOURCE) == 4'hC
    |-> FIRST_AUX_PIN == {6{TRANSMIT_IN_PROGRESS}}) else $error("tx activity code");
endmodule // tstrt_top_properties

// ---- bench/test_test_routing_and_self_test.sv ----
// testbench for the test routing and self test block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module test_test_routing_and_self_test;
  import tstrt_pkg::*;
  logic         MCLK = 0, NRST = 0, TRANSMIT_COMMAND = 0, FRAME_END = 0;
  logic         SUBCARRIER_DETECTED = 0, OSCILLATOR_STABLE = 0, OSCILLATOR_RAW = 0;
  logic         SOFT_RESET, CRC_CALCULATE_COMMAND, go = 0, done;
  logic [7:0]   SELF_TEST_CONTROL, FIFO_WDATA, e8;
  logic [4:0]   PROBE_GROUP_SELECTOR = 0;
  logic [3:0]   FIRST_AUX_SOURCE = 0, SECOND_AUX_SOURCE = 0;
  logic [2:0]   PROBE_LINE_SELECTOR = 0;
  logic [1:0]   PRBS_SELECT = 0;
  logic [5:0]   FIRST_DAC_VALUE = 0, SECOND_DAC_VALUE = 0, CORRELATOR_OUTPUT = 0, e1;
  logic [5:0]   MINIMUM_LEVEL_SIGNAL = 0, ADC_I = 0, ADC_Q = 0, FIRST_AUX_PIN, SECOND_AUX_PIN;
  logic [6:1]   PROBE_LINES;
  tstrt_rx_t    RX_SIG = '0;
  tstrt_phase_t RX_PHASE = '0, TX_PHASE = '0;
  logic         RECEIVE_IN_PROGRESS, TRANSMIT_IN_PROGRESS, PRBS_ACTIVE, PRBS_BIT;
  logic         FIFO_WRITE, SELF_TEST_BUSY;
  logic [7:0]   exp_q[$];
  logic [3:0]   codes[9] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'hC, 4'hD, 4'hE, 4'hF};
  logic [5:0]   e2;
  logic [7:0]   grp;
  logic [8:0]   r9;
  logic         rxa, txa, pb;
  // signature bytes in fifo order, first byte in the top bits
  logic [511:0] sig = {128'h00EB66BA57BF2395D0E30D3D27895CDE,
                       128'h9D3BA700215B8982513AEB020CA50049,
                       128'h7C844DB3CCD21B815D4876D5716121A9,
                       128'h86968338CF9D5B6DDC15BA3E7D953B2F};
  int           err_total = 0, n_compared = 0, seed = 2, nw = 0;
  tstrt_top i_dut (.*);
  tstrt_host_model i_host (.clk(MCLK), .go(go), .busy(SELF_TEST_BUSY),
    .soft_rst(SOFT_RESET), .ctrl(SELF_TEST_CONTROL), .crc_cmd(CRC_CALCULATE_COMMAND),
    .done(done));
  always #20 MCLK = ~MCLK;
  // ====================================
  // monitor: every written byte takes the oldest noted byte
  always @(posedge MCLK) if (NRST && FIFO_WRITE) begin
    nw++;
    if (exp_q.size() > 0) e8 = exp_q.pop_front();
    else e8 = 8'hXX;
    `CHK(FIFO_WDATA, e8)
  end
  // expected aux level for one pin code
  function automatic logic [5:0] exp_aux(input logic [3:0] c, input logic [5:0] dac);
    case (c)
      4'h1: return dac;
      4'h2: return CORRELATOR_OUTPUT;
      4'h4: return MINIMUM_LEVEL_SIGNAL;
      4'h5: return ADC_I;
      4'h6: return ADC_Q;
      4'hC: return {6{txa}};
      4'hD: return {6{rxa}};
      4'hE: return {6{SUBCARRIER_DETECTED}};
      default: return {6{pb}};
    endcase
  endfunction
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ====================================
  // main sequence: self test, random routing, prbs start and stop
  initial begin
    repeat (5) @(posedge MCLK);
    #1 NRST = 1;
    for (int i = 0; i < 64; i++) exp_q.push_back(sig[511 - 8 * i -: 8]);
    go = 1;
    wait (done);
    `CHK(nw, 64)
    repeat (200) begin
      @(posedge MCLK);
      #1 FIRST_AUX_SOURCE = codes[$unsigned($random(seed)) % 9];
      SECOND_AUX_SOURCE = codes[$unsigned($random(seed)) % 9];
      {FIRST_DAC_VALUE, SECOND_DAC_VALUE, CORRELATOR_OUTPUT, MINIMUM_LEVEL_SIGNAL} = $random(seed);
      {ADC_I, ADC_Q, RX_SIG, RX_PHASE, TX_PHASE, SUBCARRIER_DETECTED} = $random(seed);
      {OSCILLATOR_STABLE, OSCILLATOR_RAW, PROBE_LINE_SELECTOR} = $random(seed);
      PROBE_GROUP_SELECTOR = $random(seed) & 1 ? 5'h07 : 5'h0D;
      // the divided clock line runs free, so it is not picked as probe bit
      if (PROBE_GROUP_SELECTOR == 5'h0D && PROBE_LINE_SELECTOR == 3'h5) PROBE_LINE_SELECTOR = 3'h6;
      grp = (PROBE_GROUP_SELECTOR == 5'h07) ? {1'b0, RX_SIG, 2'b00}
          : {1'b0, OSCILLATOR_STABLE, 3'b000, OSCILLATOR_RAW, 2'b00};
      pb = grp[PROBE_LINE_SELECTOR];
      rxa = RX_PHASE.data_bit | RX_PHASE.crc_bit | (RX_PHASE.speed_106 & RX_PHASE.parity_bit);
      txa = TX_PHASE.data_bit | TX_PHASE.crc_bit
          | (TX_PHASE.speed_106 & (TX_PHASE.parity_bit | TX_PHASE.start_bit));
      e1 = exp_aux(FIRST_AUX_SOURCE, FIRST_DAC_VALUE);
      e2 = exp_aux(SECOND_AUX_SOURCE, SECOND_DAC_VALUE);
      @(posedge MCLK);
      #1 `CHK(FIRST_AUX_PIN, e1)
      `CHK(SECOND_AUX_PIN, e2)
      `CHK(RECEIVE_IN_PROGRESS, rxa)
      `CHK(TRANSMIT_IN_PROGRESS, txa)
      if (PROBE_GROUP_SELECTOR == 5'h07) `CHK(PROBE_LINES, {RX_SIG, 1'b0})
      else `CHK(PROBE_LINES & 6'h2F, grp[6:1])
    end
    // transmit side quiet before any prbs run
    TX_PHASE = '0;
    // prbs must not start with the sequence switched off
    for (int s = 0; s < 3; s++) begin
      PRBS_SELECT = s[1:0];
      TRANSMIT_COMMAND = 1;
      @(posedge MCLK);
      #1 TRANSMIT_COMMAND = 0;
      repeat (2) @(posedge MCLK);
      #1 `CHK(PRBS_ACTIVE, s != 0)
      // prbs9 from all ones, x^9 + x^5 + 1, one step per data bit
      if (s == 1) begin
        r9 = 9'h1FF;
        TX_PHASE.data_bit = 1'b1;
        repeat (8) begin
          @(posedge MCLK);
          #1 r9 = {r9[7:0], r9[8] ^ r9[4]};
          `CHK(PRBS_BIT, r9[0])
        end
        TX_PHASE.data_bit = 1'b0;
      end
      FRAME_END = 1;
      @(posedge MCLK);
      #1 FRAME_END = 0;
      repeat (2) @(posedge MCLK);
      #1;
    end
    conclude();
  end
  // watchdog: the whole run needs well under 1000 cycles
  initial begin
    #200000;
    err_total++;
    conclude();
  end
endmodule // test_test_routing_and_self_test
bind tstrt_top tstrt_top_properties i_chk (.*);
